// ===== testbench/adc_scan_sequencer_tb_top.sv
// Purpose: Self-checking bench for the channel scan sequencer.
// Assumes: Sixteen-channel part, zero wait state register bus.
// Notes: Expected channels go into a queue that the strobe monitor drains.
`timescale 1ns/1ps
module adc_scan_sequencer_tb_top;
  logic sys_clk = 0, rst_n = 0, psel = 0, penable = 0, pwrite = 0, convDone;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0, prdata, rd;
  logic pready, pslverr, convStrobe, clkInternal, avgAllowed, busy, err;
  logic [3:0] convChannel, lag = 4'h0, ch;
  logic [3:0] expq[$];
  int fails = 0, cmp_count = 0, cyc = 0;
  // The clock toggles every half period of 10 ns.
  always #10 sys_clk = ~sys_clk;
  asq_scan_sequencer dut (.sys_clk(sys_clk), .rst_n(rst_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .convDone(convDone), .convStrobe(convStrobe),
    .convChannel(convChannel), .clkInternal(clkInternal), .avgAllowed(avgAllowed),
    .busy(busy));
  asq_conv_model conv (.sys_clk(sys_clk), .rst_n(rst_n), .convStrobe(convStrobe), .lag(lag),
    .convDone(convDone));
  function automatic logic [31:0] mw(input logic [3:0] code, input logic [3:0] n);
    return {17'h0, code, n, 7'h0};
  endfunction
  task automatic check_reg(input logic [31:0] got, input logic [31:0] exp, input string what);
    cmp_count++;
    if (got !== exp) begin
      fails++;
      $display("unexpected at %0t: %s got %h exp %h", $time, what, got, exp);
    end
  endtask
  task automatic check_chan(input logic [3:0] got, input logic [4:0] exp);
    check_reg({28'h0, got}, {27'h0, exp}, "channel");
  endtask
  // The oldest noted channel is taken off whenever a strobe appears.
  always @(posedge sys_clk)
    if (convStrobe === 1'b1) check_chan(convChannel, expq.size() ? {1'b0, expq.pop_front()} : 5'h1f);
  // A hang counts as a mismatch and ends the run.
  always @(posedge sys_clk) begin
    cyc++;
    if (cyc == 20000) begin
      fails++;
      give_verdict();
    end
  end
  task automatic give_verdict;
    $display("comparisons %0d mismatches %0d", cmp_count, fails);
    if (fails == 0 && cmp_count > 0) $display("Simulation passed");
    else $display("Simulation failed");
    $finish;
  endtask
  // One bus transfer; an idle cycle follows so strobes never change twice in a step.
  // The wait for ready has no limit of its own, so only the bench timeout ends a hang.
  task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
    psel <= 1'b1; pwrite <= wr; paddr <= a; pwdata <= d; penable <= 1'b0;
    @(posedge sys_clk);
    penable <= 1'b1;
    do @(posedge sys_clk); while (pready !== 1'b1);
    rd = prdata;
    err = pslverr;
    psel <= 1'b0; penable <= 1'b0;
    @(posedge sys_clk);
  endtask
  // Runs one scan and checks clock mode, completion and the conversion count.
  task automatic scan(input logic [3:0] code, input logic [3:0] n, input logic ci);
    int cnt;
    cnt = expq.size();
    lag <= 4'($urandom_range(0, 3));
    apb(1'b1, asq_pkg::OFF_MODE, mw(code, n));
    apb(1'b0, asq_pkg::OFF_STATUS, 32'h0);
    check_reg({30'h0, rd[3:2]}, {30'h0, ci, ci}, "clock mode");
    apb(1'b1, asq_pkg::OFF_CTRL, 32'h1);
    while (busy === 1'b1) @(posedge sys_clk);
    apb(1'b0, asq_pkg::OFF_STATUS, 32'h0);
    check_reg({23'h0, rd[16:8]}, cnt, "count");
    check_reg(expq.size(), 0, "missing");
    $display("scan code %h done", code);
  endtask
  initial begin
    int s, n, m;
    s = $urandom(93982);
    repeat (6) @(posedge sys_clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge sys_clk);
    apb(1'b0, asq_pkg::OFF_MODE, 32'h0);
    check_reg(rd, mw(asq_pkg::RST_SCAN, asq_pkg::RST_CHAN), "reset mode");
    n = $urandom_range(0, 15);
    for (int i = 0; i <= n; i++) expq.push_back(4'(i));
    scan(asq_pkg::SCAN_STD_EXT, 4'(n), 1'b0);
    for (int i = n; i < 16; i++) expq.push_back(4'(i));
    scan(asq_pkg::SCAN_UPPER_INT, 4'(n), 1'b1);
    expq.push_back(4'hf);
    scan(asq_pkg::SCAN_UPPER_EXT, 4'hf, 1'b0);
    m = ($urandom & 32'hffff) | 32'h8001;
    apb(1'b1, asq_pkg::OFF_CUSTOM, m);
    for (int k = 0; k < 2; k++) begin
      for (int i = 0; i < 16; i++) if (m[i]) expq.push_back(4'(i));
      scan(k ? asq_pkg::SCAN_CUSTOM_EXT : asq_pkg::SCAN_CUSTOM_INT, 4'h0, !k);
    end
    apb(1'b1, asq_pkg::OFF_SEQADDR, 32'h0);
    apb(1'b1, asq_pkg::OFF_SEQLAST, 32'h5);
    for (int i = 0; i < 6; i++) begin
      if (i != 3) ch = 4'($urandom_range(0, 15));
      apb(1'b1, asq_pkg::OFF_SEQDATA, {28'h0, ch});
      expq.push_back(ch);
    end
    scan(asq_pkg::SCAN_USER, 4'h0, 1'b0);
    apb(1'b1, asq_pkg::OFF_MODE, mw(asq_pkg::SCAN_UPPER_INT, 4'h5));
    for (int c = 0; c < 16; c++) if (c == 0 || c >= 10) begin
      apb(1'b1, asq_pkg::OFF_MODE, mw(4'(c), 4'($urandom)) | ($urandom & 32'h7f));
      apb(1'b0, asq_pkg::OFF_MODE, 32'h0);
      check_reg(rd, mw(asq_pkg::SCAN_UPPER_INT, 4'h5), "held mode");
      check_reg({31'h0, clkInternal & avgAllowed}, 32'h1, "held clock");
    end
    $display("reserved code test done");
    apb(1'b0, 8'h1c, 32'h0);
    check_reg({err, rd[30:0]}, 32'h80000000, "unmapped");
    $display("unmapped access test done");
    // A stored code without a sequence must not start a scan; a stray strobe is flagged too.
    apb(1'b1, asq_pkg::OFF_MODE, mw(4'h3, 4'h2));
    apb(1'b1, asq_pkg::OFF_CTRL, 32'h1);
    apb(1'b0, asq_pkg::OFF_STATUS, 32'h0);
    check_reg({31'h0, rd[0]}, 32'h0, "no scan");
    $display("no sequence test done");
    give_verdict();
  end
endmodule // adc_scan_sequencer_tb_top

// ===== testbench/asq_conv_model.sv
// Purpose: Behavioural converter core that answers each start strobe.
// Assumes: One conversion is outstanding at a time.
// Notes: The lag input picks how many extra cycles an answer takes.
`timescale 1ns/1ps
module asq_conv_model (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic convStrobe,
  input wire logic [3:0] lag,
  output logic convDone
);
  int cnt;
  // Count down from each strobe and pulse done once, so slow answers stall the scan.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      cnt <= 0;
      convDone <= 1'b0;
    end else begin
      convDone <= (cnt == 1);
      if (convStrobe) cnt <= int'(lag) + 1;
      else if (cnt > 0) cnt <= cnt - 1;
    end
  end
endmodule // asq_conv_model

// ===== verilog/asq_pkg.sv
// Purpose: Shared constants of the converter channel scan sequencer.
// Assumes: APB register map with 32-bit aligned words.
// Notes: Scan codes follow the 4-bit scan-mode field encoding.
package asq_pkg;
  // Register byte offsets.
  localparam logic [7:0] OFF_MODE = 8'h00;
  localparam logic [7:0] OFF_CUSTOM = 8'h04;
  localparam logic [7:0] OFF_SEQLAST = 8'h08;
  localparam logic [7:0] OFF_SEQADDR = 8'h0c;
  localparam logic [7:0] OFF_SEQDATA = 8'h10;
  localparam logic [7:0] OFF_CTRL = 8'h14;
  localparam logic [7:0] OFF_STATUS = 8'h18;
  // Field positions inside the mode control word.
  localparam int SCAN_LSB = 11;
  localparam int CHAN_LSB = 7;
  // Scan-mode codes.
  localparam logic [3:0] SCAN_HOLD = 4'h0;
  localparam logic [3:0] SCAN_STD_EXT = 4'h2;
  localparam logic [3:0] SCAN_UPPER_INT = 4'h5;
  localparam logic [3:0] SCAN_UPPER_EXT = 4'h6;
  localparam logic [3:0] SCAN_CUSTOM_INT = 4'h7;
  localparam logic [3:0] SCAN_CUSTOM_EXT = 4'h8;
  localparam logic [3:0] SCAN_USER = 4'h9;
  localparam logic [3:0] SCAN_RSVD_FIRST = 4'ha;
  // Reset values.
  localparam logic [3:0] RST_SCAN = SCAN_STD_EXT;
  localparam logic [3:0] RST_CHAN = 4'h0;
  localparam logic [15:0] RST_CUSTOM = 16'h0000;
  localparam logic [7:0] RST_SEQLAST = 8'h00;
endpackage

// ===== verilog/asq_scan_sequencer.sv
// Purpose: Decodes scan mode and channel fields into a conversion sequence.
// Assumes: APB slave, zero wait state; converter core answers each strobe with convDone.
// Notes: NUM_CH is 16 or 8 depending on the part.
`timescale 1ns/1ps
module asq_scan_sequencer #(
  parameter int NUM_CH = 16
) (
  input wire logic sys_clk,
  input wire logic rst_n,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [7:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic convDone,
  output logic convStrobe,
  output logic [3:0] convChannel,
  output logic clkInternal,
  output logic avgAllowed,
  output logic busy
);
  localparam logic [3:0] TOP_CH = 4'(NUM_CH - 1);
  localparam int SCAN_LSB_W = asq_pkg::SCAN_LSB;
  localparam int CHAN_LSB_W = asq_pkg::CHAN_LSB;
  typedef enum {ST_IDLE, ST_LOAD, ST_ISSUE, ST_WAIT} asq_state_t;

  logic rstMeta, rstSync;
  logic [3:0] scanMode, chanN;
  logic [15:0] customMask;
  logic [7:0] seqLast, seqAddr, seqIdx;
  logic [8:0] resultCount;
  logic [3:0] memData, curChan;
  asq_state_t state;
  logic setup, access, wrAcc, startReq, memWe, validCode;
  logic [3:0] wrScan, wrChan, chanClamp, next_chan;
  logic lastConv, firstFound;
  logic [3:0] firstChan;

  // Reset is released through two flops so that its removal is clean.
  always_ff @(posedge sys_clk or negedge rst_n) begin
    if (!rst_n) begin
      rstMeta <= 1'b0;
      rstSync <= 1'b0;
    end else begin
      rstMeta <= 1'b1;
      rstSync <= rstMeta;
    end
  end

  // Lowest set mask bit at or above start; custom lists are ascending by construction.
  function automatic logic [4:0] find_from(input logic [15:0] m, input logic [4:0] s);
    logic [4:0] r;
    r = 5'h10;
    for (int i = 15; i >= 0; i--) begin
      if (m[i] && (5'(i) >= s) && (4'(i) <= TOP_CH)) begin
        r = 5'(i);
      end
    end
    return r;
  endfunction

  assign setup = psel && !penable;
  assign access = psel && penable && pready;
  assign wrAcc = access && pwrite;
  assign wrScan = pwdata[SCAN_LSB_W+3:SCAN_LSB_W];
  assign wrChan = pwdata[CHAN_LSB_W+3:CHAN_LSB_W];
  // Hold code and reserved codes leave the mode and channel untouched.
  assign validCode = (wrScan != asq_pkg::SCAN_HOLD) && (wrScan < asq_pkg::SCAN_RSVD_FIRST);
  assign startReq = wrAcc && (paddr == asq_pkg::OFF_CTRL) && pwdata[0] && (state == ST_IDLE);
  assign memWe = wrAcc && (paddr == asq_pkg::OFF_SEQDATA);
  // Channels above the part's top are saturated so standard and upper scans never address a missing input.
  assign chanClamp = (chanN > TOP_CH) ? TOP_CH : chanN;

  asq_seq_mem #(.DEPTH(256), .AW(8), .DW(4)) uSeqMem (
    .clk(sys_clk),
    .we(memWe),
    .waddr(seqAddr),
    .wdata(pwdata[3:0]),
    .raddr(seqIdx),
    .rdata(memData)
  );

  // APB: one wait-free access; read data latched in the setup cycle.
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h00000000;
    end else begin
      pready <= setup;
      pslverr <= setup && (paddr > asq_pkg::OFF_STATUS || paddr[1:0] != 2'h0);
      prdata <= 32'h00000000;
      if (setup && !pwrite) begin
        case (paddr)
          asq_pkg::OFF_MODE: prdata <= {17'h0, scanMode, chanN, 7'h0};
          asq_pkg::OFF_CUSTOM: prdata <= {16'h0, customMask};
          asq_pkg::OFF_SEQLAST: prdata <= {24'h0, seqLast};
          asq_pkg::OFF_SEQADDR: prdata <= {24'h0, seqAddr};
          asq_pkg::OFF_STATUS: prdata <= {15'h0, resultCount, curChan, avgAllowed,
                                          clkInternal, 1'b0, busy};
          default: prdata <= 32'h00000000;
        endcase
      end
    end
  end

  // Mode control word: scan code and binary channel number N.
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      scanMode <= asq_pkg::RST_SCAN;
      chanN <= asq_pkg::RST_CHAN;
    end else if (wrAcc && paddr == asq_pkg::OFF_MODE && validCode) begin
      scanMode <= wrScan;
      chanN <= wrChan;
    end
  end

  // Custom mask, index of the last user list entry and write pointer; the pointer steps on each data write.
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      customMask <= asq_pkg::RST_CUSTOM;
      seqLast <= asq_pkg::RST_SEQLAST;
      seqAddr <= 8'h00;
    end else if (wrAcc) begin
      if (paddr == asq_pkg::OFF_CUSTOM) customMask <= pwdata[15:0];
      if (paddr == asq_pkg::OFF_SEQLAST) seqLast <= pwdata[7:0];
      if (paddr == asq_pkg::OFF_SEQADDR) seqAddr <= pwdata[7:0];
      if (memWe) seqAddr <= seqAddr + 8'h01;
    end
  end

  // Clock source and averaging follow the selected scan mode.
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      clkInternal <= 1'b0;
      avgAllowed <= 1'b0;
    end else begin
      clkInternal <= (scanMode == asq_pkg::SCAN_UPPER_INT) ||
                     (scanMode == asq_pkg::SCAN_CUSTOM_INT);
      avgAllowed <= (scanMode == asq_pkg::SCAN_UPPER_INT) ||
                    (scanMode == asq_pkg::SCAN_CUSTOM_INT);
    end
  end

  // First channel of a scan and successor of the current one, per mode.
  always_comb begin
    logic [4:0] f;
    f = 5'h10;
    firstChan = 4'h0;
    firstFound = 1'b1;
    next_chan = curChan + 4'h1;
    lastConv = 1'b1;
    case (scanMode)
      asq_pkg::SCAN_STD_EXT: begin
        firstChan = 4'h0;
        lastConv = (curChan >= chanClamp);
      end
      asq_pkg::SCAN_UPPER_INT, asq_pkg::SCAN_UPPER_EXT: begin
        firstChan = chanClamp;
        lastConv = (curChan == TOP_CH);
      end
      asq_pkg::SCAN_CUSTOM_INT, asq_pkg::SCAN_CUSTOM_EXT: begin
        f = find_from(customMask, 5'h0);
        firstChan = f[3:0];
        firstFound = !f[4];
        f = find_from(customMask, {1'b0, curChan} + 5'h01);
        next_chan = f[3:0];
        lastConv = f[4];
      end
      asq_pkg::SCAN_USER: begin
        next_chan = memData;
        lastConv = (seqIdx == seqLast);
      end
      default: begin
        firstFound = 1'b0;
      end
    endcase
  end

  // Sequencer: load the first entry, strobe each conversion, wait for its completion.
  always_ff @(posedge sys_clk or negedge rstSync) begin
    if (!rstSync) begin
      state <= ST_IDLE;
      curChan <= 4'h0;
      seqIdx <= 8'h00;
      resultCount <= 9'h000;
      convStrobe <= 1'b0;
      convChannel <= 4'h0;
      busy <= 1'b0;
    end else begin
      convStrobe <= 1'b0;
      case (state)
        ST_IDLE: begin
          if (startReq && firstFound) begin
            state <= ST_LOAD;
            curChan <= firstChan;
            seqIdx <= 8'h00;
            resultCount <= 9'h000;
            busy <= 1'b1;
          end
        end
        ST_LOAD: begin
          // Gives the sequence memory one cycle to present the entry.
          state <= ST_ISSUE;
        end
        ST_ISSUE: begin
          convStrobe <= 1'b1;
          convChannel <= (scanMode == asq_pkg::SCAN_USER) ? memData : curChan;
          if (scanMode == asq_pkg::SCAN_USER) curChan <= memData;
          state <= ST_WAIT;
        end
        ST_WAIT: begin
          if (convDone) begin
            resultCount <= resultCount + 9'h001;
            if (lastConv) begin
              state <= ST_IDLE;
              busy <= 1'b0;
            end else if (scanMode == asq_pkg::SCAN_USER) begin
              seqIdx <= seqIdx + 8'h01;
              state <= ST_LOAD;
            end else begin
              curChan <= next_chan;
              state <= ST_ISSUE;
            end
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end

  // Checks on the decoded behaviour.
  reserved_hold_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    wrAcc && paddr == asq_pkg::OFF_MODE && pwdata[14:11] >= 4'ha |=> $stable(scanMode) && $stable(chanN))
    else $error("reserved code changed mode");
  hold_code_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    wrAcc && paddr == asq_pkg::OFF_MODE && pwdata[14:11] == 4'h0 |=> $stable(scanMode) && $stable(chanN))
    else $error("hold code changed mode");
  std_first_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && resultCount == 9'h000 && scanMode == asq_pkg::SCAN_STD_EXT |-> convChannel == 4'h0 && !avgAllowed)
    else $error("standard scan did not start at channel 0");
  upper_int_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && scanMode == asq_pkg::SCAN_UPPER_INT |-> convChannel >= chanClamp && clkInternal && avgAllowed)
    else $error("upper internal scan wrong");
  upper_ext_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && scanMode == asq_pkg::SCAN_UPPER_EXT |-> convChannel >= chanClamp && !clkInternal)
    else $error("upper external scan wrong");
  custom_int_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && scanMode == asq_pkg::SCAN_CUSTOM_INT |-> customMask[convChannel] && clkInternal)
    else $error("custom scan used unlisted channel");
  custom_ascend_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && scanMode == asq_pkg::SCAN_CUSTOM_EXT && resultCount != 9'h000
    |-> convChannel > $past(curChan, 2) && !avgAllowed)
    else $error("custom external scan not ascending");
  user_ext_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    scanMode == asq_pkg::SCAN_USER && $past(scanMode) == asq_pkg::SCAN_USER |-> !clkInternal && !avgAllowed)
    else $error("user list must use external clock");
  chan_decode_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    wrAcc && paddr == asq_pkg::OFF_MODE && validCode |=> chanN == $past(pwdata[10:7]))
    else $error("channel field not decoded");
  top_bound_a: assert property (@(posedge sys_clk) disable iff (!rstSync)
    convStrobe && scanMode != asq_pkg::SCAN_USER |-> convChannel <= TOP_CH)
    else $error("channel beyond top of part");
endmodule // asq_scan_sequencer

// ===== verilog/asq_seq_mem.sv
// Purpose: Storage for the user-defined channel sequence.
// Assumes: One write port and one read port on the same clock.
// Notes: Read data appear one cycle after the address, from a register.
`timescale 1ns/1ps
module asq_seq_mem #(
  parameter int DEPTH = 256,
  parameter int AW = 8,
  parameter int DW = 4
) (
  input wire logic clk,
  input wire logic we,
  input wire logic [AW-1:0] waddr,
  input wire logic [DW-1:0] wdata,
  input wire logic [AW-1:0] raddr,
  output logic [DW-1:0] rdata
);
  logic [DW-1:0] mem [DEPTH];

  // Entries carry no reset, so software must load them before use.
  always_ff @(posedge clk) begin
    if (we) begin
      mem[waddr] <= wdata;
    end
    rdata <= mem[raddr];
  end
endmodule // asq_seq_mem
